// *** logic/dlf_defines.svh ***
// Offsets, field positions, reset values and counts of the line fetch block.
// Behaviour
// - Next line start equals previous start plus ten-bit stride in DWORDs.
// - A running pointer holds the start of the line being fetched.
// - Video buffer length counts 64-byte segments, up to one megabyte.
// - Compressed line length, valid DWORDs plus one, flags FIFO overflow.
// - Each line fetches the nine-bit count of 8-byte quadwords.
// - With panning on, surplus fetched data at line end is dropped.
// - Horizontal timing counts character clocks of eight pixels.
// - Interlaced mode steps the vertical counter by two per line.
// - Timing registers are 32-bit words starting at offset 8330h.
// - Horizontal total, bits 26 to 19, sets character clocks per line.
// - Total may be written as pixels minus one; low three bits ignored.
// - Horizontal active bits 10 to 3 set active character clocks.
`ifndef DLF_DEFINES_SVH
`define DLF_DEFINES_SVH
`define DLF_OFF_STRIDE 16'h8324
`define DLF_OFF_BUFSZ  16'h8328
`define DLF_OFF_RSVD   16'h832C
`define DLF_OFF_HTIM1  16'h8330
`define DLF_OFF_ISTAT  16'h8340
`define DLF_OFF_IMASK  16'h8344
`define DLF_OFF_CTRL   16'h8348
`define DLF_VBUF_MSB   29
`define DLF_VBUF_LSB   16
`define DLF_CBLEN_MSB  15
`define DLF_CBLEN_LSB  9
`define DLF_FLEN_MSB   8
`define DLF_FLEN_LSB   0
`define DLF_HTOT_MSB   26
`define DLF_HTOT_LSB   19
`define DLF_HACT_MSB   10
`define DLF_HACT_LSB   3
`define DLF_HTIM_MASK  27'h7FF07FF
`define DLF_PIX_LAST   3'h7
`define DLF_QW_BYTES   22'h000008
`define DLF_CTRL_PAN   0
`define DLF_CTRL_ILACE 1
`define DLF_EV_LINE    0
`define DLF_EV_CMPOVF  1
`define DLF_EV_DONE    2
`define DLF_RST_WORD   32'h00000000
`endif

// *** logic/dlf_pkg.sv ***
// Types of the line fetch and horizontal timing block.
`default_nettype none
package dlf_pkg;
    typedef struct packed {
        logic [9:0]  stride;
        logic [29:0] bufSizes;
        logic [26:0] hTiming;
        logic [1:0]  ctrl;
        logic [2:0]  mask;
        logic [2:0]  stat;
        logic [31:0] rdData;
        logic [10:0] vCount;
        logic [6:0]  cmpCnt;
    } dlf_top_t;
    typedef struct packed {
        logic [2:0] pix;
        logic [7:0] chr;
    } dlf_tim_t;
    typedef struct packed {
        logic [21:0] ptr;
        logic        first;
        logic [8:0]  reqLeft;
        logic [21:0] addr;
        logic [8:0]  rxIdx;
        logic [8:0]  rxLeft;
        logic        pixValid;
        logic        pixDrop;
        logic [63:0] pixData;
        logic        lineDone;
    } dlf_fet_t;
endpackage
`default_nettype wire

// *** logic/dlf_line_if.sv ***
// Line control signals between the register side and the fetch engine.
`default_nettype none
interface dlf_line_if;
    logic        lineStart;
    logic        frameStart;
    logic [9:0]  stride;
    logic [8:0]  fetchLen;
    logic [7:0]  activeChars;
    logic        panEnable;
    logic [21:0] linePtr;
    logic        lineDone;
    modport ctl (output lineStart, frameStart, stride, fetchLen, activeChars, panEnable,
                 input linePtr, lineDone);
    modport fet (input lineStart, frameStart, stride, fetchLen, activeChars, panEnable,
                 output linePtr, lineDone);
endinterface
`default_nettype wire

// *** logic/dlf_htimer.sv ***
// Horizontal character clock counter.
`default_nettype none
`include "dlf_defines.svh"
module dlf_htimer
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic [7:0] hTotal,
    output logic [7:0]      charCount,
    output logic [2:0]      pixPhase,
    output logic            lineStart
);
    import dlf_pkg::*;
    dlf_tim_t s;
    dlf_tim_t n;
    always_comb
    begin
        n = s;
        n.pix = s.pix + 3'h1;
        if (s.pix == `DLF_PIX_LAST)
        begin
            n.chr = (s.chr >= hTotal) ? 8'h00 : s.chr + 8'h01;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            s <= '0;
        else
            s <= n;
    end
    assign charCount = s.chr;
    assign pixPhase  = s.pix;
    assign lineStart = (s.pix == `DLF_PIX_LAST) && (s.chr >= hTotal);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_char_eight_pix: assert property ($changed(charCount) |-> $past(pixPhase) == 3'h7)
        else $error("Character count moved mid character.");
endmodule
`default_nettype wire

// *** logic/dlf_fetch.sv ***
// Frame buffer line fetch engine with line pointer and surplus drop.
`default_nettype none
`include "dlf_defines.svh"
module dlf_fetch
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    dlf_line_if.fet          bus,
    input  wire logic        memReady,
    input  wire logic        memRdValid,
    input  wire logic [63:0] memRdData,
    output logic             memReq,
    output logic [21:0]      memAddr,
    output logic             pixValid,
    output logic             pixDrop,
    output logic [63:0]      pixData
);
    import dlf_pkg::*;
    dlf_fet_t s;
    dlf_fet_t n;
    logic [21:0] nextPtr;
    always_comb
    begin
        n = s;
        n.pixValid = 1'b0;
        n.pixDrop = 1'b0;
        n.lineDone = 1'b0;
        nextPtr = s.first ? s.ptr : s.ptr + {10'h000, bus.stride, 2'b00};
        if (memReq && memReady)
        begin
            n.reqLeft = s.reqLeft - 9'h001;
            n.addr = s.addr + `DLF_QW_BYTES;
        end
        if (memRdValid && s.rxLeft != 9'h000)
        begin
            // Data beyond the active width only serves pan alignment.
            if (bus.panEnable && s.rxIdx > {1'b0, bus.activeChars})
                n.pixDrop = 1'b1;
            else
            begin
                n.pixValid = 1'b1;
                n.pixData = memRdData;
            end
            n.rxIdx = s.rxIdx + 9'h001;
            n.rxLeft = s.rxLeft - 9'h001;
            n.lineDone = (s.rxLeft == 9'h001);
        end
        if (bus.frameStart)
        begin
            n.ptr = 22'h000000;
            n.first = 1'b1;
            n.reqLeft = 9'h000;
            n.rxLeft = 9'h000;
        end
        else if (bus.lineStart)
        begin
            n.ptr = nextPtr;
            n.first = 1'b0;
            n.addr = nextPtr;
            n.reqLeft = bus.fetchLen;
            n.rxLeft = bus.fetchLen;
            n.rxIdx = 9'h000;
        end
    end
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            s <= '0;
        else
            s <= n;
    end
    assign memReq = (s.reqLeft != 9'h000);
    assign memAddr = s.addr;
    assign pixValid = s.pixValid;
    assign pixDrop = s.pixDrop;
    assign pixData = s.pixData;
    assign bus.linePtr = s.ptr;
    assign bus.lineDone = s.lineDone;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_ptr_advance: assert property (bus.lineStart && !bus.frameStart && !s.first |=>
        s.ptr == $past(s.ptr) + {10'h000, $past(bus.stride), 2'b00})
        else $error("Line pointer did not advance by the stride.");
    a_req_count: assert property (bus.lineStart && !bus.frameStart |=>
        s.reqLeft == $past(bus.fetchLen) && memAddr == bus.linePtr)
        else $error("Line fetch count not loaded.");
    a_surplus_drop: assert property (memRdValid && s.rxLeft != 9'h000 && bus.panEnable &&
        s.rxIdx > {1'b0, bus.activeChars} && !bus.lineStart && !bus.frameStart |=>
        pixDrop && !pixValid)
        else $error("Surplus quadword was not dropped.");
    c_drop: cover property (pixDrop);
endmodule
`default_nettype wire

// *** logic/dlf_top.sv ***
// Register file, interrupts and vertical stepping of the line fetch block.
`default_nettype none
`include "dlf_defines.svh"
module dlf_top
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [15:0] regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdData,
    input  wire logic        frameStart,
    input  wire logic        cmpValid,
    input  wire logic        memReady,
    input  wire logic        memRdValid,
    input  wire logic [63:0] memRdData,
    output logic             memReq,
    output logic [21:0]      memAddr,
    output logic             pixValid,
    output logic             pixDrop,
    output logic [63:0]      pixData,
    output logic [7:0]       charCount,
    output logic             displayActive,
    output logic [10:0]      vCount,
    output logic [19:0]      vidBufBytes,
    output logic             irq
);
    import dlf_pkg::*;

    dlf_top_t s;
    dlf_top_t n;
    logic [31:0] rdMux;
    logic [7:0]  hTotal;
    logic [7:0]  hActive;
    logic [6:0]  cbLen;
    logic [2:0]  pixPhase;
    logic        lineStart;
    logic        cmpOverflow;
    logic [2:0]  events;
    logic        statRead;

    dlf_line_if lineBus();

    dlf_htimer uTimer
    (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .hTotal    (hTotal),
        .charCount (charCount),
        .pixPhase  (pixPhase),
        .lineStart (lineStart)
    );

    dlf_fetch uFetch
    (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .bus        (lineBus.fet),
        .memReady   (memReady),
        .memRdValid (memRdValid),
        .memRdData  (memRdData),
        .memReq     (memReq),
        .memAddr    (memAddr),
        .pixValid   (pixValid),
        .pixDrop    (pixDrop),
        .pixData    (pixData)
    );

    // Only the character part of each timing field is used.
    assign hTotal = s.hTiming[`DLF_HTOT_MSB:`DLF_HTOT_LSB];
    assign hActive = s.hTiming[`DLF_HACT_MSB:`DLF_HACT_LSB];
    assign cbLen = s.bufSizes[`DLF_CBLEN_MSB:`DLF_CBLEN_LSB];

    assign lineBus.lineStart = lineStart;
    assign lineBus.frameStart = frameStart;
    assign lineBus.stride = s.stride;
    assign lineBus.fetchLen = s.bufSizes[`DLF_FLEN_MSB:`DLF_FLEN_LSB];
    assign lineBus.activeChars = hActive;
    assign lineBus.panEnable = s.ctrl[`DLF_CTRL_PAN];

    // A line holds cbLen minus one valid DWORDs; one more overflows the FIFO.
    // The check does not rely on software keeping cbLen at or below 41h.
    assign cmpOverflow = cmpValid && ({1'b0, s.cmpCnt} + 8'h01 >= {1'b0, cbLen});

    assign events[`DLF_EV_LINE] = lineStart;
    assign events[`DLF_EV_CMPOVF] = cmpOverflow;
    assign events[`DLF_EV_DONE] = lineBus.lineDone;

    assign statRead = regRd && (regAddr == `DLF_OFF_ISTAT);

    always_comb
    begin
        case (regAddr)
            `DLF_OFF_STRIDE:
                rdMux = {22'h000000, s.stride};
            `DLF_OFF_BUFSZ:
                rdMux = {2'h0, s.bufSizes};
            `DLF_OFF_HTIM1:
                rdMux = {5'h00, s.hTiming};
            `DLF_OFF_ISTAT:
                rdMux = {29'h00000000, s.stat};
            `DLF_OFF_IMASK:
                rdMux = {29'h00000000, s.mask};
            `DLF_OFF_CTRL:
                rdMux = {30'h00000000, s.ctrl};
            default:
                rdMux = `DLF_RST_WORD;
        endcase
    end

    always_comb
    begin
        n = s;
        n.rdData = regRd ? rdMux : `DLF_RST_WORD;
        if (regWr)
        begin
            case (regAddr)
                `DLF_OFF_STRIDE:
                    n.stride = regWrData[9:0];
                `DLF_OFF_BUFSZ:
                    n.bufSizes = regWrData[29:0];
                `DLF_OFF_HTIM1:
                    n.hTiming = regWrData[26:0] & `DLF_HTIM_MASK;
                `DLF_OFF_IMASK:
                    n.mask = regWrData[2:0];
                `DLF_OFF_CTRL:
                    n.ctrl = regWrData[1:0];
                default:
                    n.ctrl = s.ctrl;
            endcase
        end
        // A new event in the read cycle survives the clear.
        n.stat = (statRead ? 3'h0 : s.stat) | events;
        if (frameStart)
            n.vCount = 11'h000;
        else if (lineStart)
            n.vCount = s.vCount + (s.ctrl[`DLF_CTRL_ILACE] ? 11'h002 : 11'h001);
        if (lineStart)
            n.cmpCnt = 7'h00;
        else if (cmpValid && s.cmpCnt != 7'h7F)
            n.cmpCnt = s.cmpCnt + 7'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            s <= '0;
        else
            s <= n;
    end

    assign regRdData = s.rdData;
    assign vCount = s.vCount;
    assign vidBufBytes = {s.bufSizes[`DLF_VBUF_MSB:`DLF_VBUF_LSB], 6'h00};
    assign displayActive = (charCount <= hActive);
    assign irq = |(s.stat & s.mask);

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_htim_readback: assert property (regWr && regAddr == `DLF_OFF_HTIM1 ##1
        regRd && regAddr == `DLF_OFF_HTIM1 && !regWr |=>
        regRdData[26:16] == $past(regWrData[26:16], 2))
        else $error("Timing word did not read back at its offset.");

    a_rd_only_once: assert property (!regRd |=> regRdData == 32'h00000000)
        else $error("Read data stood outside its cycle.");

    a_rsvd_zero: assert property (regRd && regAddr == `DLF_OFF_RSVD |=> regRdData == 32'h0)
        else $error("Reserved word read nonzero.");

    a_total_wrap: assert property (charCount == hTotal && pixPhase == 3'h7 |=>
        charCount == 8'h00 && $past(lineStart))
        else $error("Counter did not wrap at the total.");

    a_low_ignored: assert property (regWr && regAddr == `DLF_OFF_HTIM1 |=>
        hTotal == $past(regWrData[26:19]))
        else $error("Total took its low bits into account.");

    a_vbuf_units: assert property (regWr && regAddr == `DLF_OFF_BUFSZ |=>
        vidBufBytes == {$past(regWrData[29:16]), 6'h00})
        else $error("Video buffer length not in 64-byte units.");

    a_vert_step: assert property (lineStart && !frameStart |=>
        vCount == $past(vCount) + ($past(s.ctrl[1]) ? 11'h002 : 11'h001))
        else $error("Vertical counter stepped wrongly.");

    a_cmp_overflow: assert property (cmpOverflow |=> s.stat[1] ##1 irq || !s.mask[1])
        else $error("Compressed overflow not flagged.");

    a_stat_sticky: assert property (s.stat[0] && !statRead |=> s.stat[0])
        else $error("Status bit lost without a read.");

    c_overflow: cover property (cmpOverflow);
    c_interlace: cover property (lineStart && s.ctrl[1]);
    c_line_done: cover property (lineBus.lineDone ##[1:20] lineStart);
endmodule
`default_nettype wire

// *** tb/dlf_mem_model.sv ***
// Frame buffer memory model answering quadword requests in order.
`default_nettype none
module dlf_mem_model
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        slow,
    input  wire logic        memReq,
    input  wire logic [21:0] memAddr,
    output logic             memReady,
    output logic             memRdValid,
    output logic [63:0]      memRdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [21:0] pend[$];
    logic [1:0]  waitCnt = 2'h0;
    logic        phase = 1'b0;
    initial
    begin
        memReady = 1'b0;
        memRdValid = 1'b0;
        memRdData = 64'h0;
    end
    function automatic logic [63:0] pat(input logic [21:0] a);
        return {a[9:0], ~a, a[9:0], a};
    endfunction
    // Idle data is inverted every cycle so a stale quadword is never taken as fresh.
    always @(posedge ref_clk)
    begin
        phase <= ~phase;
        memRdValid <= 1'b0;
        memRdData <= ~memRdData;
        if (reset)
        begin
            pend.delete();
            waitCnt <= 2'h0;
            memReady <= 1'b0;
        end
        else
        begin
            memReady <= slow ? phase : 1'b1;
            if (memReq && memReady)
                pend.push_back(memAddr);
            if (waitCnt != 2'h0)
                waitCnt <= waitCnt - 2'h1;
            else if (pend.size() != 0)
            begin
                memRdValid <= 1'b1;
                memRdData <= pat(pend.pop_front());
                waitCnt <= slow ? 2'h3 : 2'h0;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/dlf_top_tb.sv ***
// Self-checking bench of the line fetch and horizontal timing block.
`default_nettype none
`include "dlf_defines.svh"
module dlf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] H_TOT = 8'h05;
    localparam logic [7:0] H_ACT = 8'h02;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic [15:0] regAddr = 16'h0;
    logic [31:0] regWrData = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        frameStart = 1'b0;
    logic        cmpValid = 1'b0;
    logic        slow = 1'b0;
    logic        watch = 1'b0;
    logic        rdPend = 1'b0;
    logic        gapOk = 1'b0;
    logic [7:0]  lastChar = 8'h0;
    logic [31:0] care = 32'h0;
    int          gap = 0;
    int          drops = 0;
    int          fails = 0;
    int          compares = 0;
    logic [31:0] rdExp[$];
    logic [31:0] rdCare[$];
    logic [21:0] addrQ[$];
    logic [63:0] pixQ[$];
    logic [15:0] offs[8] = '{16'h8324, 16'h8328, 16'h832C, 16'h8330,
                             16'h8340, 16'h8344, 16'h8348, 16'h8400};
    logic        memReady, memRdValid, memReq, pixValid, pixDrop, displayActive, irq;
    logic [31:0] regRdData;
    logic [63:0] memRdData, pixData;
    logic [21:0] memAddr;
    logic [7:0]  charCount;
    logic [10:0] vCount;
    logic [19:0] vidBufBytes;

    always #25 ref_clk = ~ref_clk;

    dlf_top i_dlf_top (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .frameStart(frameStart), .cmpValid(cmpValid), .memReady(memReady),
        .memRdValid(memRdValid), .memRdData(memRdData), .memReq(memReq),
        .memAddr(memAddr), .pixValid(pixValid), .pixDrop(pixDrop), .pixData(pixData),
        .charCount(charCount), .displayActive(displayActive), .vCount(vCount),
        .vidBufBytes(vidBufBytes), .irq(irq));
    dlf_mem_model i_dlf_mem_model (.ref_clk(ref_clk), .reset(reset), .slow(slow),
        .memReq(memReq), .memAddr(memAddr), .memReady(memReady),
        .memRdValid(memRdValid), .memRdData(memRdData));

    function automatic logic [63:0] pat(input logic [21:0] a);
        return {a[9:0], ~a, a[9:0], a};
    endfunction
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s: expected %0h, seen %0h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] c);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        rdExp.push_back(e);
        rdCare.push_back(c);
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask
    // Write then read back with no gap, so the readback path is exercised at full rate.
    task automatic wrRd(input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        regRd <= 1'b1;
        rdExp.push_back(e);
        rdCare.push_back(ALL);
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask
    task automatic waitChar(input logic [7:0] v);
        do @(posedge ref_clk); while (charCount !== v);
    endtask
    task automatic pulseCmp(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            cmpValid <= 1'b1;
            @(posedge ref_clk);
            cmpValid <= 1'b0;
        end
    endtask
    // Each run restarts the frame mid-line; frameStart cancels any line still in flight.
    task automatic run(input logic pn, input logic il, input logic sl);
        logic [31:0] w;
        logic [21:0] a;
        w = $urandom;
        slow <= sl;
        wr(`DLF_OFF_STRIDE, w);
        rd(`DLF_OFF_STRIDE, w & 32'h000003FF, ALL);
        wr(`DLF_OFF_CTRL, {30'h0, il, pn});
        waitChar(8'h03);
        frameStart <= 1'b1;
        watch <= 1'b1;
        drops = 0;
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 4; i++)
            begin
                a = 22'(k * w[9:0] * 4 + i * 8);
                addrQ.push_back(a);
                if (!pn || i <= H_ACT)
                    pixQ.push_back(pat(a));
            end
        @(posedge ref_clk);
        frameStart <= 1'b0;
        repeat (3)
        begin
            waitChar(8'h00);
            waitChar(8'h01);
        end
        waitChar(8'h03);
        watch <= 1'b0;
        chk("vCount", il ? 6 : 3, vCount);
        chk("drops", pn ? 3 : 0, drops);
        chk("addrLeft", 0, addrQ.size());
        chk("pixLeft", 0, pixQ.size());
    endtask

    always @(posedge ref_clk)
    begin
        rdPend <= regRd;
        if (rdPend)
        begin
            care = rdCare.pop_front();
            chk("regRdData", rdExp.pop_front() & care, regRdData & care);
        end
        if (watch && memReq && memReady)
        begin
            chk("memReqQueued", 1, addrQ.size() != 0);
            if (addrQ.size() != 0)
                chk("memAddr", addrQ.pop_front(), memAddr);
        end
        if (watch && pixValid)
        begin
            chk("pixQueued", 1, pixQ.size() != 0);
            if (pixQ.size() != 0)
                chk("pixData", pixQ.pop_front(), pixData);
        end
        if (watch && pixDrop)
            drops++;
        if (watch)
        begin
            chk("displayActive", charCount <= H_ACT, displayActive);
            if (charCount !== lastChar)
            begin
                if (gapOk)
                    chk("charGap", 8, gap);
                if (gapOk && charCount == 8'h00)
                    chk("wrapFrom", H_TOT, lastChar);
                gapOk <= 1'b1;
                gap <= 1;
            end
            else
                gap <= gap + 1;
        end
        else
            gapOk <= 1'b0;
        lastChar <= charCount;
    end

    initial
    begin
        #2000000;
        fails++;
        wrap_up();
    end

    initial
    begin
        logic [31:0] w;
        logic [13:0] vb;
        w = $urandom(91742);
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        foreach (offs[i])
            rd(offs[i], 32'h0, offs[i] == `DLF_OFF_ISTAT ? 32'hFFFFFFF8 : ALL);
        chk("irqReset", 0, irq);
        w = $urandom;
        wr(`DLF_OFF_RSVD, w);
        rd(`DLF_OFF_RSVD, 32'h0, ALL);
        wr(16'h8400, w);
        rd(16'h8400, 32'h0, ALL);
        w = $urandom;
        w[26:19] = H_TOT;
        w[10:3] = H_ACT;
        wrRd(`DLF_OFF_HTIM1, w, w & `DLF_HTIM_MASK);
        vb = 14'($urandom);
        w = $urandom;
        w[29:16] = vb;
        w[15:9] = 7'h03;
        w[8:0] = 9'h004;
        wr(`DLF_OFF_BUFSZ, w);
        rd(`DLF_OFF_BUFSZ, w & 32'h3FFFFFFF, ALL);
        chk("vidBufBytes", {vb, 6'h00}, vidBufBytes);
        run(1'b0, 1'b0, 1'b0);
        run(1'b1, 1'b1, 1'b1);
        slow <= 1'b0;
        waitChar(8'h01);
        rd(`DLF_OFF_ISTAT, 32'h0, 32'h0);
        rd(`DLF_OFF_ISTAT, 32'h0, 32'h00000007);
        wr(`DLF_OFF_IMASK, 32'h00000007);
        @(posedge ref_clk);
        chk("irqClear", 0, irq);
        pulseCmp(2);
        rd(`DLF_OFF_ISTAT, 32'h0, 32'h00000002);
        pulseCmp(1);
        repeat (2) @(posedge ref_clk);
        chk("irqOverflow", 1, irq);
        rd(`DLF_OFF_ISTAT, 32'h00000002, 32'h00000002);
        wr(`DLF_OFF_IMASK, 32'h00000001);
        waitChar(8'h01);
        chk("irqLine", 1, irq);
        wr(`DLF_OFF_IMASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("irqMasked", 0, irq);
        wrap_up();
    end
endmodule
`default_nettype wire
